/* dcw_pkg.sv */
// package: control word decoder constants and types
// ==========================================================
package dcw_pkg;
    // ==========================================================
    // control word bit positions
    localparam int CW_RAMP_STOP = 0;
    localparam int CW_COAST_STOP = 1;
    localparam int CW_QUICK_STOP = 2;
    localparam int CW_OP_ENABLE = 3;
    localparam int CW_RAMP_OUT_REL = 4;
    localparam int CW_RAMP_RUN = 5;
    localparam int CW_RAMP_IN_REL = 6;
    localparam int CW_FAULT_RESET = 7;
    localparam int CW_GRANT = 10;
    localparam int CW_LOC_SEL = 11;
    // ==========================================================
    // status word bit positions
    localparam int SW_RDY_ON = 0;
    localparam int SW_RDY_RUN = 1;
    localparam int SW_RDY_REF = 2;
    localparam int SW_FAULT = 3;
    localparam int SW_COAST_INACT = 4;
    localparam int SW_QUICK_INACT = 5;
    localparam int SW_SWON_INHIB = 6;
    localparam int SW_ALARM = 7;
    localparam int SW_SETPOINT = 8;
    localparam int SW_REMOTE = 9;
    localparam int SW_ABOVE_LIM = 10;
    localparam int SW_LOC = 11;
    localparam int SW_RUN_EN = 12;
    // ==========================================================
    // apb register map
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_CONFIG = 8'h08;
    localparam logic [7:0] A_ACTUAL = 8'h0c;
    localparam logic [7:0] A_REF = 8'h10;
    localparam logic [7:0] A_TOL = 8'h14;
    localparam logic [7:0] A_STATE = 8'h18;
    // config bits
    localparam int CF_RUN_EN_FB = 0;
    localparam int CF_RAMP_IN_FB = 1;
    localparam int CF_RESET_FB = 2;
    localparam int CF_LOC_FB = 3;
    localparam logic [3:0] CONFIG_RST = 4'hf;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] TOL_RST = 16'h0000;
    // ==========================================================
    // drive states
    typedef enum logic [2:0] {
        ST_SWON_INHIBIT,
        ST_READY_SWON,
        ST_READY_RUN,
        ST_OP_ENABLED,
        ST_RAMP_OFF,
        ST_COAST_OFF,
        ST_QUICK_OFF,
        ST_FAULT
    } dcw_state_t;
endpackage

/* dcw_cmd_if.sv */
// interface: decoded commands from decoder to state machine
`timescale 1ns/1ps
interface dcw_cmd_if;
    import dcw_pkg::*;
    logic ramp_stop_n;
    logic coast_stop_n;
    logic quick_stop_n;
    logic operation_enable;
    logic run_enable;
    logic fault_reset;
    logic ramp_done;
    logic stop_done;
    dcw_state_t state;
    modport src (output ramp_stop_n, coast_stop_n, quick_stop_n, operation_enable,
        run_enable, fault_reset, ramp_done, stop_done, input state);
    modport dst (input ramp_stop_n, coast_stop_n, quick_stop_n, operation_enable,
        run_enable, fault_reset, ramp_done, stop_done, output state);
endinterface

/* dcw_fsm.sv */
// module: drive state machine
`timescale 1ns/1ps
module dcw_fsm
    import dcw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // fault input
    input wire logic fault_in,
    // commands
    dcw_cmd_if.dst cmd
);
    dcw_state_t state_r;
    dcw_state_t state_nxt;

    assign cmd.state = state_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_FAULT: begin
                if (cmd.fault_reset && !fault_in) begin
                    state_nxt = ST_SWON_INHIBIT;
                end
            end
            ST_COAST_OFF: begin
                if (cmd.stop_done) begin
                    state_nxt = ST_SWON_INHIBIT;
                end
            end
            ST_QUICK_OFF: begin
                if (cmd.stop_done) begin
                    state_nxt = ST_SWON_INHIBIT;
                end
            end
            ST_RAMP_OFF: begin
                if (!cmd.coast_stop_n) begin
                    state_nxt = ST_COAST_OFF;
                end else if (!cmd.quick_stop_n) begin
                    state_nxt = ST_QUICK_OFF;
                end else if (cmd.ramp_done) begin
                    state_nxt = ST_READY_SWON;
                end
            end
            ST_SWON_INHIBIT: begin
                if (cmd.coast_stop_n && cmd.quick_stop_n && !cmd.ramp_stop_n) begin
                    state_nxt = ST_READY_SWON;
                end
            end
            ST_READY_SWON: begin
                if (!cmd.coast_stop_n || !cmd.quick_stop_n) begin
                    state_nxt = ST_SWON_INHIBIT;
                end else if (cmd.ramp_stop_n) begin
                    state_nxt = ST_READY_RUN;
                end
            end
            ST_READY_RUN, ST_OP_ENABLED: begin
                if (!cmd.coast_stop_n) begin
                    state_nxt = ST_COAST_OFF;
                end else if (!cmd.quick_stop_n) begin
                    state_nxt = ST_QUICK_OFF;
                end else if (!cmd.ramp_stop_n) begin
                    state_nxt = ST_RAMP_OFF;
                end else if (cmd.operation_enable && cmd.run_enable) begin
                    state_nxt = ST_OP_ENABLED;
                end else begin
                    state_nxt = ST_READY_RUN;
                end
            end
        endcase
        if (fault_in) begin
            state_nxt = ST_FAULT;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_SWON_INHIBIT;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end
endmodule

/* dcw_top.sv */
// module: control word decoder top with apb registers
`timescale 1ns/1ps
module dcw_top
    import dcw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // drive side inputs
    input wire logic ext_run_enable,
    input wire logic fault_in,
    input wire logic alarm_in,
    input wire logic remote_in,
    input wire logic above_limit_in,
    input wire logic ramp_done,
    input wire logic stop_done,
    // drive side outputs
    output logic ramp_out_zero,
    output logic ramp_hold,
    output logic ramp_in_zero,
    output logic modulating,
    output logic coast_active,
    output logic quick_active,
    output logic ramp_stop_active,
    output logic location_select,
    output logic fault_reset_pulse,
    output logic [15:0] status_word
);
    dcw_cmd_if cmd ();

    logic [15:0] ctrl_r;
    logic [15:0] ctrl_prev_r;
    logic [3:0] config_r;
    logic [15:0] actual_r;
    logic [15:0] ref_r;
    logic [15:0] tol_r;
    logic new_word_r;
    logic granted;
    logic fault_edge;
    logic [15:0] err_abs;
    logic wr_en;
    logic setpoint_reached;
    dcw_state_t st;

    // ==========================================================
    // apb access
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && clk_en;

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            unique case (paddr)
                A_CTRL, A_STATUS, A_CONFIG, A_ACTUAL, A_REF, A_TOL, A_STATE: pslverr = 1'b0;
                default: pslverr = 1'b1;
            endcase
        end
    end

    // control word written by client through adapter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RST;
            new_word_r <= 1'b0;
        end else if (clk_en) begin
            new_word_r <= wr_en && (paddr == A_CTRL);
            if (wr_en && paddr == A_CTRL) begin
                ctrl_r <= pwdata[15:0];
            end
        end
    end

    // previous word kept for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_prev_r <= CTRL_RST;
        end else if (clk_en && new_word_r) begin
            ctrl_prev_r <= ctrl_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            config_r <= CONFIG_RST;
            actual_r <= 16'h0000;
            ref_r <= 16'h0000;
            tol_r <= TOL_RST;
        end else if (wr_en) begin
            if (paddr == A_CONFIG) begin
                config_r <= pwdata[3:0];
            end
            if (paddr == A_ACTUAL) begin
                actual_r <= pwdata[15:0];
            end
            if (paddr == A_REF) begin
                ref_r <= pwdata[15:0];
            end
            if (paddr == A_TOL) begin
                tol_r <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            unique case (paddr)
                A_CTRL: prdata <= {16'h0000, ctrl_r};
                A_STATUS: prdata <= {16'h0000, status_word};
                A_CONFIG: prdata <= {28'h0000000, config_r};
                A_ACTUAL: prdata <= {16'h0000, actual_r};
                A_REF: prdata <= {16'h0000, ref_r};
                A_TOL: prdata <= {16'h0000, tol_r};
                A_STATE: prdata <= {29'h00000000, st};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // command decode
    // bits 8, 9, 12..15 are never decoded
    assign granted = ctrl_r[CW_GRANT];
    assign fault_edge = new_word_r && ctrl_r[CW_FAULT_RESET]
        && !ctrl_prev_r[CW_FAULT_RESET];

    assign cmd.ramp_stop_n = ctrl_r[CW_RAMP_STOP];
    assign cmd.coast_stop_n = ctrl_r[CW_COAST_STOP];
    assign cmd.quick_stop_n = ctrl_r[CW_QUICK_STOP];
    assign cmd.operation_enable = granted && ctrl_r[CW_OP_ENABLE];
    assign cmd.run_enable = config_r[CF_RUN_EN_FB]
        ? (granted && ctrl_r[CW_OP_ENABLE]) : ext_run_enable;
    assign cmd.fault_reset = fault_edge && granted && config_r[CF_RESET_FB];
    assign cmd.ramp_done = ramp_done;
    assign cmd.stop_done = stop_done;
    assign st = cmd.state;

    dcw_fsm u_fsm (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .fault_in(fault_in),
        .cmd(cmd)
    );

    // ==========================================================
    // setpoint tolerance
    assign err_abs = (actual_r >= ref_r) ? 16'(actual_r - ref_r) : 16'(ref_r - actual_r);
    assign setpoint_reached = (st == ST_OP_ENABLED) && (err_abs <= tol_r);

    // ==========================================================
    // drive outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ramp_out_zero <= 1'b1;
            ramp_hold <= 1'b1;
            ramp_in_zero <= 1'b1;
            modulating <= 1'b0;
            coast_active <= 1'b0;
            quick_active <= 1'b0;
            ramp_stop_active <= 1'b0;
            location_select <= 1'b0;
            fault_reset_pulse <= 1'b0;
        end else if (clk_en) begin
            ramp_out_zero <= !(granted && ctrl_r[CW_RAMP_OUT_REL]);
            ramp_hold <= !(granted && ctrl_r[CW_RAMP_RUN]);
            ramp_in_zero <= config_r[CF_RAMP_IN_FB]
                && !(granted && ctrl_r[CW_RAMP_IN_REL]);
            modulating <= (st == ST_OP_ENABLED);
            coast_active <= (st == ST_COAST_OFF);
            quick_active <= (st == ST_QUICK_OFF);
            ramp_stop_active <= (st == ST_RAMP_OFF);
            if (granted && config_r[CF_LOC_FB]) begin
                location_select <= ctrl_r[CW_LOC_SEL];
            end
            fault_reset_pulse <= cmd.fault_reset;
        end
    end

    // status word back to client
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_word <= 16'h0000;
        end else if (clk_en) begin
            status_word <= 16'h0000;
            status_word[SW_RDY_ON] <= (st == ST_READY_SWON) || (st == ST_READY_RUN)
                || (st == ST_OP_ENABLED);
            status_word[SW_RDY_RUN] <= (st == ST_READY_RUN) || (st == ST_OP_ENABLED);
            status_word[SW_RDY_REF] <= (st == ST_OP_ENABLED);
            status_word[SW_FAULT] <= (st == ST_FAULT);
            status_word[SW_COAST_INACT] <= (st != ST_COAST_OFF);
            status_word[SW_QUICK_INACT] <= (st != ST_QUICK_OFF);
            status_word[SW_SWON_INHIB] <= (st == ST_SWON_INHIBIT);
            status_word[SW_ALARM] <= alarm_in;
            status_word[SW_SETPOINT] <= setpoint_reached;
            status_word[SW_REMOTE] <= remote_in;
            status_word[SW_ABOVE_LIM] <= above_limit_in;
            status_word[SW_LOC] <= location_select;
            status_word[SW_RUN_EN] <= cmd.run_enable;
        end
    end
endmodule

/* dcw_properties.sv */
// checker: port assertions for the control word decoder
`timescale 1ns/1ps
module dcw_properties
    import dcw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // drive side
    input wire logic modulating,
    input wire logic ramp_out_zero,
    input wire logic ramp_hold,
    input wire logic ramp_in_zero,
    input wire logic location_select,
    input wire logic fault_reset_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic wr_ctrl;
    logic wr_cfg;
    logic in_fb_r;
    logic loc_fb_r;
    logic loc_bit;
    assign wr_ctrl = psel && penable && pwrite && clk_en && paddr == A_CTRL;
    assign wr_cfg = psel && penable && pwrite && clk_en && paddr == A_CONFIG;
    assign loc_bit = pwdata[CW_LOC_SEL];
    // fieldbus source selections mirrored from config writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_fb_r <= CONFIG_RST[CF_RAMP_IN_FB];
            loc_fb_r <= CONFIG_RST[CF_LOC_FB];
        end else if (wr_cfg) begin
            in_fb_r <= pwdata[CF_RAMP_IN_FB];
            loc_fb_r <= pwdata[CF_LOC_FB];
        end
    end
    // ==========================================================
    // apb responses and control word writes
    sequence s_granted;
        wr_ctrl && pwdata[CW_GRANT];
    endsequence
    property p_loc;
        s_granted ##0 loc_fb_r |-> ##2 location_select == $past(loc_bit, 2);
    endproperty
    chk_pready_high: assert property (psel |-> pready)
        else $error("pready low in transfer");
    chk_unmapped_err: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
        else $error("no error on unmapped access");
    chk_coast_stop: assert property (wr_ctrl && !pwdata[CW_COAST_STOP] |-> ##[1:4] !modulating)
        else $error("coast stop ignored");
    chk_quick_stop: assert property (wr_ctrl && !pwdata[CW_QUICK_STOP] |-> ##[1:4] !modulating)
        else $error("quick stop ignored");
    chk_op_inhibit: assert property (s_granted ##0 !pwdata[CW_OP_ENABLE] |-> ##[1:4] !modulating)
        else $error("operation not inhibited");
    chk_out_zero: assert property (s_granted ##0 !pwdata[CW_RAMP_OUT_REL] |-> ##[1:4] ramp_out_zero)
        else $error("ramp output not zeroed");
    chk_ramp_held: assert property (s_granted ##0 !pwdata[CW_RAMP_RUN] |-> ##[1:4] ramp_hold)
        else $error("ramp not held");
    chk_in_zero: assert property (s_granted ##0 (in_fb_r && !pwdata[CW_RAMP_IN_REL])
        |-> ##[1:4] ramp_in_zero)
        else $error("ramp input not zeroed");
    chk_loc_follow: assert property (p_loc)
        else $error("location select wrong");
    chk_pulse_single: assert property (fault_reset_pulse |=> !fault_reset_pulse)
        else $error("fault reset pulse too long");
endmodule

/* dcw_client.sv */
// model: fieldbus client issuing apb transfers
`timescale 1ns/1ps
module dcw_client (
    // clock
    input wire logic clk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ==========================================================
    // one transfer, released lines show inverted values
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge clk);
    endtask
    task automatic start();
        logic [31:0] q;
        logic e;
        xfer(8'h00, 1'b1, 32'h047e, q, e);
        xfer(8'h00, 1'b1, 32'h047f, q, e);
    endtask
endmodule

/* dcw_tb.sv */
// testbench: scenario run for the control word decoder
`timescale 1ns/1ps
module drive_control_word_decoder_tb_top;
    import dcw_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, ext_run_enable = 1'b0, fault_in = 1'b0;
    logic alarm_in = 1'b0, remote_in = 1'b0, above_limit_in = 1'b0;
    logic ramp_done = 1'b0, stop_done = 1'b0, last_err;
    logic psel, penable, pwrite, pready, pslverr, ramp_out_zero, ramp_hold, ramp_in_zero;
    logic modulating, coast_active, quick_active, ramp_stop_active, location_select;
    logic fault_reset_pulse;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] status_word;
    int mismatches = 0, n_compared = 0, cycles = 0, pulses = 0, p0;
    always #50 clk = ~clk;
    dcw_top dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_run_enable(ext_run_enable),
        .fault_in(fault_in), .alarm_in(alarm_in), .remote_in(remote_in),
        .above_limit_in(above_limit_in), .ramp_done(ramp_done), .stop_done(stop_done),
        .ramp_out_zero(ramp_out_zero), .ramp_hold(ramp_hold), .ramp_in_zero(ramp_in_zero),
        .modulating(modulating), .coast_active(coast_active), .quick_active(quick_active),
        .ramp_stop_active(ramp_stop_active), .location_select(location_select),
        .fault_reset_pulse(fault_reset_pulse), .status_word(status_word));
    dcw_client cl_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ==========================================================
    // shared tasks
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (fault_reset_pulse === 1'b1) pulses <= pulses + 1;
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        cl_u.xfer(a, 1'b1, d, q, last_err);
        repeat (3) @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        cl_u.xfer(a, 1'b0, 32'h0, q, last_err);
        check(q, exp);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        check(status_word, 32'h0070);
        check({ramp_out_zero, ramp_hold, ramp_in_zero, modulating}, 32'he);
        rd_chk(A_CONFIG, 32'hf);
        rd_chk(A_STATE, 32'h0);
        rd_chk(8'h40, 32'h0);
        check(last_err, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_run();
        cl_u.start();
        repeat (3) @(posedge clk);
        rd_chk(A_STATE, 32'h3);
        check({modulating, status_word[2:0]}, 32'hf);
        for (int b = 4; b < 7; b++) begin
            wr(A_CTRL, 32'h047f & ~(32'h1 << b));
            check({ramp_out_zero, ramp_hold, ramp_in_zero}, 32'h4 >> (b - 4));
            wr(A_CTRL, 32'h047f);
        end
        wr(A_CTRL, 32'h0067);
        check({modulating, ramp_out_zero}, 32'h1);
        wr(A_CTRL, 32'hf77f);
        rd_chk(A_STATE, 32'h3);
        wr(A_CTRL, 32'h0c7f);
        check({location_select, status_word[SW_LOC]}, 32'h3);
        wr(A_CTRL, 32'h047f);
        check({location_select, status_word[SW_LOC]}, 32'h0);
        $display("test run bits done");
    endtask
    task automatic t_setpoint();
        alarm_in <= 1'b1;
        remote_in <= 1'b1;
        above_limit_in <= 1'b1;
        wr(A_ACTUAL, 32'd100);
        wr(A_REF, 32'd105);
        wr(A_TOL, 32'd5);
        check(status_word[10:7], 32'hf);
        wr(A_TOL, 32'd4);
        check(status_word[10:7], 32'hd);
        $display("test setpoint done");
    endtask
    task automatic t_op_inhibit();
        wr(A_CTRL, 32'h0477);
        rd_chk(A_STATE, 32'h2);
        check({modulating, status_word[SW_RDY_REF]}, 32'h0);
        wr(A_CONFIG, 32'he);
        wr(A_CTRL, 32'h047f);
        rd_chk(A_STATE, 32'h2);
        ext_run_enable <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(A_STATE, 32'h3);
        wr(A_CONFIG, 32'hf);
        $display("test inhibit done");
    endtask
    task automatic t_stops();
        wr(A_CTRL, 32'h047e);
        rd_chk(A_STATE, 32'h4);
        check(ramp_stop_active, 32'h1);
        ramp_done <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(A_STATE, 32'h1);
        ramp_done <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            cl_u.start();
            wr(A_CTRL, i ? 32'h047b : 32'h047d);
            rd_chk(A_STATE, 32'h5 + i);
            check({coast_active, quick_active}, i ? 32'h1 : 32'h2);
            stop_done <= 1'b1;
            repeat (4) @(posedge clk);
            rd_chk(A_STATE, 32'h0);
            stop_done <= 1'b0;
        end
        $display("test stops done");
    endtask
    task automatic t_fault();
        cl_u.start();
        fault_in <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(A_STATE, 32'h7);
        check(status_word[SW_FAULT], 32'h1);
        fault_in <= 1'b0;
        wr(A_CTRL, 32'h047f);
        rd_chk(A_STATE, 32'h7);
        p0 = pulses;
        wr(A_CTRL, 32'h04ff);
        wr(A_CTRL, 32'h04ff);
        check(pulses - p0, 32'h1);
        rd_chk(A_STATE, 32'h0);
        clk_en <= 1'b0;
        wr(A_CTRL, 32'h047e);
        clk_en <= 1'b1;
        rd_chk(A_CTRL, 32'h04ff);
        rd_chk(A_STATE, 32'h0);
        $display("test fault done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_run();
        t_setpoint();
        t_op_inhibit();
        t_stops();
        t_fault();
        close_out();
    end
endmodule
bind dcw_top dcw_properties chk_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .modulating(modulating),
    .ramp_out_zero(ramp_out_zero), .ramp_hold(ramp_hold), .ramp_in_zero(ramp_in_zero),
    .location_select(location_select), .fault_reset_pulse(fault_reset_pulse));
